//--- rtl/dmamp_fifo.sv
// Synchronous FIFO carrying data words of one transfer
module dmamp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clock,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_reg;
    logic [AW-1:0]    wr_next;
    logic [AW-1:0]    rd_reg;
    logic [AW-1:0]    rd_next;
    logic [AW:0]      cnt_reg;
    logic [AW:0]      cnt_next;
    logic             push;
    logic             pop;

    assign in_ready  = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rd_reg];

    always_comb
    begin
        push     = in_valid && in_ready;
        pop      = out_valid && out_ready;
        wr_next  = push ? wr_reg + 1'b1 : wr_reg;
        rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
        cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_reg] <= in_data;
        end
        if (sys_rst)
        begin
            wr_reg  <= '0;
            rd_reg  <= '0;
            cnt_reg <= '0;
        end
        else
        begin
            wr_reg  <= wr_next;
            rd_reg  <= rd_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

//--- rtl/dmamp_pkg.sv
// Package of constants for the DMA mid-point flag and busy block
package dmamp_pkg;
    localparam int        NUM_CHAN        = 7;
    localparam int        REG_W           = 8;
    localparam int        SIZE_W          = 16;
    localparam logic [3:0] PAGE_MIDPOINT  = 4'h2;
    localparam logic [7:0] ADDR_MIDPOINT  = 8'hd4;
    localparam logic [3:0] PAGE_BUSY      = 4'h2;
    localparam logic [7:0] ADDR_BUSY      = 8'hd5;
    localparam logic [3:0] PAGE_CONFIG    = 4'h2;
    localparam logic [7:0] ADDR_CONFIG    = 8'hd6;
    localparam logic [3:0] PAGE_SELECT    = 4'h2;
    localparam logic [7:0] ADDR_SELECT    = 8'hd7;
    localparam logic [3:0] PAGE_SIZE_LO   = 4'h2;
    localparam logic [7:0] ADDR_SIZE_LO   = 8'hd8;
    localparam logic [3:0] PAGE_SIZE_HI   = 4'h2;
    localparam logic [7:0] ADDR_SIZE_HI   = 8'hd9;
    localparam logic [3:0] PAGE_WRAP      = 4'h2;
    localparam logic [7:0] ADDR_WRAP      = 8'hda;
    localparam int        HALF_EN_BIT     = 6;
    localparam int        WRAP_BIT        = 0;
    localparam logic [2:0] SEL_INVALID    = 3'h7;
    localparam logic [7:0] FLAG_RESET     = 8'h00;
    localparam logic [7:0] BUSY_RESET     = 8'h00;
    localparam int        FIFO_DEPTH      = 16;
endpackage

//--- rtl/dmamp_top.sv
// Mid-point flags, busy register and transfer sequencing of a seven-channel DMA unit
//
// Behaviour
// RULE1 - Bit 7 of the mid-point flag and busy registers reads zero and ignores writes.
// RULE2 - A channel's flag bit sets when its offset equals size/2 (even) or (size-1)/2 (odd).
// RULE3 - A set mid-point flag holds until software writes it zero or reset occurs.
// RULE4 - The mid-point request of a channel rises only while its config bit 6 is set.
// RULE5 - Writing 1 to a busy bit starts that channel; writing 0 does nothing.
// RULE6 - A busy bit reads 1 while its channel transfers and 0 when idle.
// RULE7 - The mid-point flag register decodes at page 0x2, address 0xd4.
// RULE8 - Config, size and wrap act on the channel picked by a 3-bit selector; 7 is invalid.
// RULE9 - A transfer completes at offset size-1, and the offset returns to zero if wrap is set.
// RULE10 - Completion clears the busy bit; all flag and busy bits reset to zero.
module dmamp_top #(
    parameter int NCH   = dmamp_pkg::NUM_CHAN,
    parameter int SW    = dmamp_pkg::SIZE_W,
    parameter int DW    = dmamp_pkg::REG_W,
    parameter int DEPTH = dmamp_pkg::FIFO_DEPTH
) (
    input  wire logic          clock,
    input  wire logic          sys_rst,
    input  wire logic [3:0]    sfr_page,
    input  wire logic [7:0]    sfr_addr,
    input  wire logic          sfr_wr,
    input  wire logic          sfr_rd,
    input  wire logic [7:0]    sfr_wdata,
    output logic [7:0]         sfr_rdata,
    input  wire logic [DW-1:0] src_data,
    input  wire logic          src_valid,
    output logic               src_ready,
    output logic [DW-1:0]      sink_data,
    output logic               sink_valid,
    input  wire logic          sink_ready,
    output logic [2:0]         xfer_chan,
    output logic [SW-1:0]      chan_offset_counter,
    output logic [NCH-1:0]     half_irq
);
    // ****************************************
    // State
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_MOVE = 2'b01} dmamp_state_t;

    dmamp_state_t     st_reg;
    dmamp_state_t     st_next;
    logic [NCH-1:0]   flag_reg;
    logic [NCH-1:0]   flag_next;
    logic [NCH-1:0]   busy_reg;
    logic [NCH-1:0]   busy_next;
    logic [NCH-1:0]   irq_reg;
    logic [NCH-1:0]   irq_next;
    logic [2:0]       sel_reg;
    logic [2:0]       sel_next;
    logic [2:0]       cur_reg;
    logic [2:0]       cur_next;
    logic [7:0]       cfg_reg  [NCH];
    logic [7:0]       cfg_next [NCH];
    logic [SW-1:0]    size_reg [NCH];
    logic [SW-1:0]    size_next[NCH];
    logic [SW-1:0]    off_reg  [NCH];
    logic [SW-1:0]    off_next [NCH];
    logic [NCH-1:0]   wrap_reg;
    logic [NCH-1:0]   wrap_next;
    logic [7:0]       rd_reg;
    logic [7:0]       rd_next;
    logic             f_in_valid;
    logic             f_in_ready;
    logic             f_out_valid;
    logic             step;
    logic             sel_ok;

    function automatic logic hit(input logic [3:0] pg, input logic [7:0] ad,
                                 input logic [3:0] p, input logic [7:0] a);
        hit = (pg == p) && (ad == a);
    endfunction

    // Mid-point offset of a size
    function automatic logic [SW-1:0] midpoint(input logic [SW-1:0] sz);
        midpoint = sz[0] ? (sz - 1'b1) >> 1 : sz >> 1; // RULE2
    endfunction

    // ****************************************
    // Data path FIFO
    // ****************************************
    dmamp_fifo #(.WIDTH(DW), .DEPTH(DEPTH)) u_fifo (
        .clock     (clock),
        .sys_rst   (sys_rst),
        .in_data   (src_data),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .out_data  (sink_data),
        .out_valid (f_out_valid),
        .out_ready (sink_ready)
    );

    assign sink_valid = f_out_valid;
    assign step       = (st_reg == ST_MOVE) && src_valid && f_in_ready;

    // ****************************************
    // Next state
    // ****************************************
    always_comb
    begin
        st_next   = st_reg;
        flag_next = flag_reg;
        busy_next = busy_reg;
        sel_next  = sel_reg;
        cur_next  = cur_reg;
        wrap_next = wrap_reg;
        cfg_next  = cfg_reg;
        size_next = size_reg;
        off_next  = off_reg;
        rd_next   = rd_reg;
        sel_ok    = (sel_reg != dmamp_pkg::SEL_INVALID); // RULE8
        f_in_valid = (st_reg == ST_MOVE) && src_valid;
        if (sfr_wr)
        begin
            if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_MIDPOINT, dmamp_pkg::ADDR_MIDPOINT))
                flag_next = flag_reg & sfr_wdata[NCH-1:0]; // RULE3 RULE7 RULE1
            if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_BUSY, dmamp_pkg::ADDR_BUSY))
                busy_next = busy_reg | sfr_wdata[NCH-1:0]; // RULE5 RULE1
            if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_SELECT, dmamp_pkg::ADDR_SELECT))
                sel_next = sfr_wdata[2:0];
            if (sel_ok)
            begin
                if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_CONFIG, dmamp_pkg::ADDR_CONFIG))
                    cfg_next[sel_reg] = sfr_wdata; // RULE8
                if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_SIZE_LO, dmamp_pkg::ADDR_SIZE_LO))
                    size_next[sel_reg][7:0] = sfr_wdata;
                if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_SIZE_HI, dmamp_pkg::ADDR_SIZE_HI))
                    size_next[sel_reg][SW-1:8] = sfr_wdata[SW-9:0];
                if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_WRAP, dmamp_pkg::ADDR_WRAP))
                begin
                    wrap_next[sel_reg] = sfr_wdata[dmamp_pkg::WRAP_BIT];
                    off_next[sel_reg]  = '0;
                end
            end
        end
        unique case (st_reg)
            ST_IDLE:
            begin
                for (int i = NCH - 1; i >= 0; i--)
                begin
                    if (busy_reg[i])
                    begin
                        cur_next = 3'(i);
                        st_next  = ST_MOVE;
                    end
                end
            end
            ST_MOVE:
            begin
                if (step)
                begin
                    if (off_reg[cur_reg] == midpoint(size_reg[cur_reg]))
                        flag_next[cur_reg] = 1'b1; // RULE2 RULE3
                    if (off_reg[cur_reg] == size_reg[cur_reg] - 1'b1)
                    begin
                        busy_next[cur_reg] = 1'b0; // RULE10 RULE9
                        st_next = ST_IDLE;
                        if (wrap_reg[cur_reg])
                            off_next[cur_reg] = '0; // RULE9
                    end
                    else
                    begin
                        off_next[cur_reg] = off_reg[cur_reg] + 1'b1;
                    end
                end
            end
            default:
            begin
                st_next = ST_IDLE;
            end
        endcase
        if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_MIDPOINT, dmamp_pkg::ADDR_MIDPOINT))
            rd_next = {1'b0, flag_reg}; // RULE1
        else if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_BUSY, dmamp_pkg::ADDR_BUSY))
            rd_next = {1'b0, busy_reg}; // RULE6 RULE1
        else if (hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_SELECT, dmamp_pkg::ADDR_SELECT))
            rd_next = {5'h00, sel_reg};
        else if (sel_ok && hit(sfr_page, sfr_addr, dmamp_pkg::PAGE_CONFIG,
                               dmamp_pkg::ADDR_CONFIG))
            rd_next = cfg_reg[sel_reg];
        else
            rd_next = 8'h00;
        if (!sfr_rd)
            rd_next = rd_reg;
        for (int i = 0; i < NCH; i++)
            irq_next[i] = flag_next[i] && cfg_reg[i][dmamp_pkg::HALF_EN_BIT]; // RULE4
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            st_reg   <= ST_IDLE;
            flag_reg <= dmamp_pkg::FLAG_RESET[NCH-1:0]; // RULE10
            busy_reg <= dmamp_pkg::BUSY_RESET[NCH-1:0]; // RULE10
            irq_reg  <= '0;
            sel_reg  <= '0;
            cur_reg  <= '0;
            wrap_reg <= '0;
            rd_reg   <= 8'h00;
            for (int i = 0; i < NCH; i++)
            begin
                cfg_reg[i]  <= 8'h00;
                size_reg[i] <= '0;
                off_reg[i]  <= '0;
            end
        end
        else
        begin
            st_reg   <= st_next;
            flag_reg <= flag_next;
            busy_reg <= busy_next;
            irq_reg  <= irq_next;
            sel_reg  <= sel_next;
            cur_reg  <= cur_next;
            wrap_reg <= wrap_next;
            rd_reg   <= rd_next;
            cfg_reg  <= cfg_next;
            size_reg <= size_next;
            off_reg  <= off_next;
        end
    end

    assign sfr_rdata           = rd_reg;
    assign half_irq            = irq_reg;
    assign xfer_chan           = cur_reg;
    assign chan_offset_counter = off_reg[cur_reg];
    assign src_ready           = (st_reg == ST_MOVE) && f_in_ready;

    // ****************************************
    // Checks
    // ****************************************
    property p_top_zero;
        @(posedge clock) disable iff (sys_rst) sfr_rd |=> !sfr_rdata[7];
    endproperty
    a_top_zero: assert property (p_top_zero) else $error("bit 7 read nonzero"); // RULE1

    property p_flag_sticky;
        @(posedge clock) disable iff (sys_rst)
        (flag_reg[0] && !(sfr_wr && sfr_addr == dmamp_pkg::ADDR_MIDPOINT)) |=> flag_reg[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("flag cleared by hw"); // RULE3

    property p_irq_gate;
        @(posedge clock) disable iff (sys_rst)
        half_irq[0] |-> $past(cfg_reg[0][dmamp_pkg::HALF_EN_BIT]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without enable"); // RULE4

    property p_start;
        @(posedge clock) disable iff (sys_rst)
        (sfr_wr && sfr_page == dmamp_pkg::PAGE_BUSY && sfr_addr == dmamp_pkg::ADDR_BUSY
         && sfr_wdata[1]) |=> busy_reg[1];
    endproperty
    a_start: assert property (p_start) else $error("busy write did not start"); // RULE5

    property p_done;
        @(posedge clock) disable iff (sys_rst)
        (step && off_reg[cur_reg] == size_reg[cur_reg] - 1'b1) |=> st_reg == ST_IDLE;
    endproperty
    a_done: assert property (p_done) else $error("no completion at size-1"); // RULE9 RULE10

    property p_mid;
        @(posedge clock) disable iff (sys_rst)
        (step && off_reg[cur_reg] == midpoint(size_reg[cur_reg])) |=> flag_reg[$past(cur_reg)];
    endproperty
    a_mid: assert property (p_mid) else $error("mid-point flag missing"); // RULE2
endmodule

//--- sim/dmamp_far_model.sv
// Far-side model: word source and stallable sink of the DMA data stream
module dmamp_far_model (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [15:0] credit,
    input  wire logic        stall,
    output logic [7:0]       src_data,
    output logic             src_valid,
    input  wire logic        src_ready,
    input  wire logic [7:0]  sink_data,
    input  wire logic        sink_valid,
    output logic             sink_ready,
    output logic [15:0]      sent_cnt,
    output logic [15:0]      recv_cnt,
    output logic [15:0]      recv_bad
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] rx_exp;
    initial
    begin
        src_data = 8'h00;
        src_valid = 1'b0;
        sink_ready = 1'b0;
    end
    // Counts words both ways; sink checks the running sequence
    always @(posedge clock)
    begin
        if (sys_rst)
        begin
            sent_cnt = 16'h0000;
            recv_cnt = 16'h0000;
            recv_bad = 16'h0000;
            rx_exp = 8'h00;
        end
        else
        begin
            if (src_valid && src_ready)
                sent_cnt = sent_cnt + 16'h0001;
            if (sink_valid && sink_ready)
            begin
                if (sink_data !== rx_exp)
                    recv_bad = recv_bad + 16'h0001;
                rx_exp = rx_exp + 8'h01;
                recv_cnt = recv_cnt + 16'h0001;
            end
        end
        #1;
        // Word held until taken; idle data toggles
        src_valid = !sys_rst && (sent_cnt < credit);
        src_data = src_valid ? sent_cnt[7:0] : ~src_data;
        sink_ready = !stall;
    end
endmodule

//--- sim/dmamp_top_tb_top.sv
// Self-checking testbench of the DMA mid-point flag and busy block
module dmamp_top_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [3:0]  sfr_page = 4'h2;
    logic [7:0]  sfr_addr = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_wdata = 8'h00;
    logic [15:0] credit = 16'h0000;
    logic        stall = 1'b0;
    logic [7:0]  sfr_rdata;
    logic [7:0]  src_data;
    logic [7:0]  sink_data;
    logic        src_valid;
    logic        src_ready;
    logic        sink_valid;
    logic        sink_ready;
    logic [2:0]  xfer_chan;
    logic [15:0] chan_offset_counter;
    logic [6:0]  half_irq;
    logic [15:0] sent_cnt;
    logic [15:0] recv_cnt;
    logic [15:0] recv_bad;
    int          error_cnt = 0;
    int          n_tests = 0;
    always #25 clock = ~clock;
    dmamp_top dut (.clock(clock), .sys_rst(sys_rst), .sfr_page(sfr_page), .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
        .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
        .sink_data(sink_data), .sink_valid(sink_valid), .sink_ready(sink_ready),
        .xfer_chan(xfer_chan), .chan_offset_counter(chan_offset_counter), .half_irq(half_irq));
    dmamp_far_model far (.clock(clock), .sys_rst(sys_rst), .credit(credit), .stall(stall),
        .src_data(src_data), .src_valid(src_valid), .src_ready(src_ready),
        .sink_data(sink_data), .sink_valid(sink_valid), .sink_ready(sink_ready),
        .sent_cnt(sent_cnt), .recv_cnt(recv_cnt), .recv_bad(recv_bad));
    // ************************************************
    // Tasks
    // ************************************************
    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        #1;
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(posedge clock);
        #1;
        sfr_wr = 1'b0;
    endtask
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        #1;
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(posedge clock);
        #1;
        sfr_rd = 1'b0;
        check({8'h00, sfr_rdata}, {8'h00, exp});
    endtask
    task feed(input logic [15:0] n);
        int k;
        credit = credit + n;
        for (k = 0; k < 400 && sent_cnt < credit; k++)
            @(posedge clock);
        repeat (3) @(posedge clock);
        #1;
    endtask
    task setup(input logic [7:0] ch, input logic [7:0] cfg, input logic [7:0] sz,
               input logic [7:0] wrap);
        wr(8'hd7, ch);
        wr(8'hd6, cfg);
        wr(8'hd8, sz);
        wr(8'hd9, 8'h00);
        wr(8'hda, wrap);
    endtask
    task finish_test;
        $display("errors %0d, checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ************************************************
    // Watchdog
    // ************************************************
    initial
    begin
        #500000;
        error_cnt++;
        finish_test;
    end
    // ************************************************
    // Tests
    // ************************************************
    initial
    begin
        int k;
        repeat (4) @(posedge clock);
        #1;
        sys_rst = 1'b0;
        rd_chk(8'hd4, 8'h00);
        rd_chk(8'hd5, 8'h00);
        rd_chk(8'h10, 8'h00);
        wr(8'hd4, 8'hff);
        rd_chk(8'hd4, 8'h00);
        wr(8'hd5, 8'h80);
        wr(8'hd5, 8'h00);
        rd_chk(8'hd5, 8'h00);
        // Channel 0, odd size 5, mid-point enabled
        setup(8'h00, 8'h40, 8'h05, 8'h00);
        wr(8'hd5, 8'h01);
        rd_chk(8'hd5, 8'h01);
        feed(16'h0002);
        rd_chk(8'hd4, 8'h00);
        feed(16'h0001);
        rd_chk(8'hd4, 8'h01);
        check({9'h000, half_irq}, 16'h0001);
        feed(16'h0002);
        rd_chk(8'hd5, 8'h00);
        check(chan_offset_counter, 16'h0004);
        rd_chk(8'hd4, 8'h01);
        wr(8'hd4, 8'h00);
        rd_chk(8'hd4, 8'h00);
        check({9'h000, half_irq}, 16'h0000);
        // Channel 6, even size 4, wrap, mid-point disabled; invalid selector write
        setup(8'h06, 8'h00, 8'h04, 8'h01);
        wr(8'hd7, 8'h07);
        wr(8'hd8, 8'h02);
        wr(8'hd7, 8'h06);
        wr(8'hd5, 8'h40);
        rd_chk(8'hd5, 8'h40);
        feed(16'h0002);
        rd_chk(8'hd4, 8'h00);
        feed(16'h0001);
        rd_chk(8'hd4, 8'h40);
        check({9'h000, half_irq}, 16'h0000);
        feed(16'h0001);
        rd_chk(8'hd5, 8'h00);
        check({13'h0000, xfer_chan}, 16'h0006);
        check(chan_offset_counter, 16'h0000);
        // Channel 1, size 20, sink stalled until the buffer refuses
        stall = 1'b1;
        setup(8'h01, 8'h00, 8'h14, 8'h00);
        wr(8'hd5, 8'h02);
        credit = credit + 16'h0014;
        repeat (60) @(posedge clock);
        #1;
        check(sent_cnt, 16'h0019);
        check({15'h0000, src_ready}, 16'h0000);
        stall = 1'b0;
        for (k = 0; k < 400 && recv_cnt < 16'h001d; k++)
            @(posedge clock);
        #1;
        check(recv_cnt, 16'h001d);
        check(recv_bad, 16'h0000);
        rd_chk(8'hd5, 8'h00);
        rd_chk(8'hd4, 8'h42);
        finish_test;
    end
endmodule
